// ### hw/fp_sys_exec.sv
// Execution unit for extension-register stack and store transfers,
// square root, subtract, breakpoint, mask change and barriers.
// Assumes one core clock; the decoder and memory share that clock.
`timescale 1ns/1ps
`include "fp_sys_exec_defs.svh"

module fp_sys_exec
  import fp_sys_exec_pkg::*;
(
  input  wire logic        i_ref_clk,       // Core clock
  input  wire logic        i_reset_n,       // Async reset, low
  input  wire logic        i_issue_valid,   // Instruction offered
  input  wire op_t         i_op,            // Decoded operation
  input  wire logic        i_cond_pass,     // Condition true
  input  wire logic        i_privileged,    // Privileged code
  input  wire logic [4:0]  i_first_reg,     // First S or D reg
  input  wire logic [4:0]  i_reg_count,     // List length
  input  wire logic        i_dbl,           // Doubleword regs
  input  wire logic        i_decrement,     // Decrement-before
  input  wire logic        i_writeback,     // Base writeback
  input  wire logic [31:0] i_base,          // Base or stack ptr
  input  wire logic [7:0]  i_imm_words,     // Offset in words
  input  wire logic        i_imm_sub,       // Offset negative
  input  wire logic [4:0]  i_dst,           // Destination S reg
  input  wire logic [4:0]  i_src_a,         // First source
  input  wire logic [4:0]  i_src_b,         // Second source
  input  wire logic        i_sel_int,       // i flag
  input  wire logic        i_sel_fault,     // f flag
  input  wire logic        i_mask_set,      // Disable form
  input  wire logic        i_mem_ack,       // Word accepted
  input  wire logic [31:0] i_mem_rdata,     // Load data
  input  wire logic        i_mem_idle,      // No access pending
  input  wire logic [4:0]  i_dbg_idx,       // Reg peek index
  output logic             o_busy,          // Unit occupied
  output logic             o_done,          // Retire pulse
  output logic             o_mem_req,       // Memory request
  output logic             o_mem_we,        // Request is store
  output logic [31:0]      o_mem_addr,      // Word address
  output logic [31:0]      o_mem_wdata,     // Store data
  output logic             o_base_wb_valid, // Base update pulse
  output logic [31:0]      o_base_wb_value, // New base value
  output logic             o_debug_req,     // Enter debug pulse
  output logic             o_pipe_flush,    // Refetch pulse
  output logic             o_interrupt_mask_bit, // Interrupt mask
  output logic             o_fault_mask_bit,     // Fault mask
  output logic [31:0]      o_dbg_data       // Reg peek data
);

  //--------------------------------------------------------------
  // Storage and state
  //--------------------------------------------------------------
  logic [31:0] fpr [`NUM_SREGS];
  state_t      state_r;
  logic        busy_r;
  logic        done_r;
  logic        load_r;
  logic        wb_en_r;
  logic [31:0] wb_val_r;
  logic [4:0]  idx_r;
  logic [5:0]  left_r;
  logic        dmb_pend_r;
  logic [47:0] rad_r;
  logic [25:0] rem_r;
  logic [23:0] root_r;
  logic [4:0]  cnt_r;
  logic [8:0]  sq_exp_r;
  logic        sq_spec_r;
  logic [31:0] sq_spec_val_r;
  logic [4:0]  dst_r;

  logic        accept;
  logic        exec;
  logic [4:0]  first_s;
  logic [5:0]  nwords;
  logic [7:0]  nbytes;
  logic [31:0] sp_lo;
  logic [31:0] sp_hi;
  logic [31:0] str_addr;
  logic        rf_we;
  logic [4:0]  rf_idx;
  logic [31:0] rf_data;
  logic [27:0] rem_n;
  logic [27:0] trial;
  logic [31:0] sq_result;
  logic        mem_go;

  //--------------------------------------------------------------
  // Subtract datapath
  //--------------------------------------------------------------
  // Truncating adder; denormals flush to zero to keep it small.
  function automatic logic [31:0] fsub(input logic [31:0] a,
                                       input logic [31:0] b);
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] t;
    logic [7:0]  d;
    logic [27:0] mx;
    logic [27:0] my;
    logic [27:0] s;
    logic [9:0]  e;
    x = a;
    y = {~b[31], b[30:0]};
    if (x[30:0] < y[30:0]) begin
      t = x;
      x = y;
      y = t;
    end
    if (x[30:23] == `FP_EXP_MAX) begin
      if (y[30:23] == `FP_EXP_MAX && x[31] != y[31])
        return `FP_NAN;
      return x;
    end
    d  = x[30:23] - y[30:23];
    mx = (x[30:23] == 8'h00) ? 28'h0 : {2'b01, x[22:0], 3'b000};
    my = (y[30:23] == 8'h00) ? 28'h0 : {2'b01, y[22:0], 3'b000};
    my = (d > `SUB_SHIFT_MAX) ? 28'h0 : (my >> d);
    s  = (x[31] == y[31]) ? mx + my : mx - my;
    e  = {2'b00, x[30:23]};
    if (s[27]) begin
      s = s >> 1;
      e = e + 10'h001;
    end
    // Bounded shift loop stands in for a leading-zero counter
    for (int i = 0; i < 26; i++) begin
      if (!s[26] && s != 28'h0) begin
        s = s << 1;
        e = e - 10'h001;
      end
    end
    if (!s[26] || e[9] || e == 10'h000)
      return 32'h0;
    if (e >= 10'h0ff)
      return {x[31], `FP_EXP_MAX, 23'h0};
    return {x[31], e[7:0], s[25:3]};
  endfunction

  //--------------------------------------------------------------
  // Issue decode and address math
  //--------------------------------------------------------------
  // Failed condition retires empty; breakpoint and mask change
  // ignore the condition.
  assign accept   = i_issue_valid && !busy_r;
  assign exec     = i_cond_pass || i_op == OP_BREAKPOINT_INSTR || i_op == OP_CPS;
  assign first_s  = i_dbl ? {i_first_reg[3:0], 1'b0} : i_first_reg;
  assign nwords   = i_op == OP_STR ? (i_dbl ? 6'h02 : 6'h01)
                  : (i_dbl ? {i_reg_count, 1'b0} : {1'b0, i_reg_count});
  assign nbytes   = {nwords, 2'b00};
  assign sp_lo    = i_base - {24'h0, nbytes};
  assign sp_hi    = i_base + {24'h0, nbytes};
  assign str_addr = i_imm_sub ? i_base - {22'h0, i_imm_words, 2'b00}
                              : i_base + {22'h0, i_imm_words, 2'b00};

  // Barrier still holding back the next access
  // later access waits for idle memory
  assign mem_go = !dmb_pend_r || i_mem_idle;

  // Square root step
  assign rem_n     = {rem_r, rad_r[47:46]};
  assign trial     = {2'b00, root_r, 2'b01};
  assign sq_result = sq_spec_r ? sq_spec_val_r
                   : {1'b0, sq_exp_r[7:0], root_r[22:0]};

  //--------------------------------------------------------------
  // Register file write select
  //--------------------------------------------------------------
  always_comb begin
    rf_we   = 1'b0;
    rf_idx  = idx_r;
    rf_data = i_mem_rdata;
    if (state_r == ST_MEM && o_mem_req && i_mem_ack && load_r) begin
      rf_we = 1'b1;
    end else if (state_r == ST_SQRT && cnt_r == 5'h00) begin
      rf_we   = 1'b1;
      rf_idx  = dst_r;
      rf_data = sq_result;
    end else if (accept && exec && i_op == OP_SUB) begin
      rf_we   = 1'b1;
      rf_idx  = i_dst;
      rf_data = fsub(fpr[i_src_a], fpr[i_src_b]);
    end
  end

  // Register array, no reset: contents are software state
  always_ff @(posedge i_ref_clk) begin
    if (rf_we)
      fpr[rf_idx] <= rf_data;
  end

  // Registered peek port for software visibility
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      o_dbg_data <= 32'h0;
    else
      o_dbg_data <= fpr[i_dbg_idx];
  end

  //--------------------------------------------------------------
  // Exception masks
  //--------------------------------------------------------------
  // Mask change takes effect at retire of the instruction itself.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_interrupt_mask_bit <= `MASK_RST;
      o_fault_mask_bit     <= `MASK_RST;
    end else if (accept && i_op == OP_CPS && i_privileged) begin
      if (i_sel_int)
        o_interrupt_mask_bit <= i_mask_set;
      if (i_sel_fault)
        o_fault_mask_bit <= i_mask_set;
    end
  end

  //--------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------
  // Condition flags are never touched: no path here writes them.
  // flags untouched
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r  <= ST_IDLE;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      load_r   <= 1'b0;
      wb_en_r  <= 1'b0;
      wb_val_r <= 32'h0;
      idx_r    <= 5'h00;
      left_r   <= 6'h00;
      dst_r    <= 5'h00;
      o_mem_req   <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_addr  <= 32'h0;
      o_mem_wdata <= 32'h0;
      o_base_wb_valid <= 1'b0;
      o_base_wb_value <= 32'h0;
      o_debug_req  <= 1'b0;
      o_pipe_flush <= 1'b0;
    end else begin
      done_r          <= 1'b0;
      o_base_wb_valid <= 1'b0;
      o_debug_req     <= 1'b0;
      o_pipe_flush    <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (accept) begin
            busy_r <= 1'b1;
            done_r <= 1'b1;
            busy_r <= 1'b0;
            if (exec) begin
              case (i_op)
                OP_POP, OP_PUSH, OP_STM, OP_STR: begin
                  busy_r  <= 1'b1;
                  done_r  <= 1'b0;
                  state_r <= ST_MEM;
                  load_r  <= i_op == OP_POP;
                  o_mem_we <= i_op != OP_POP;
                  idx_r   <= first_s;
                  left_r  <= nwords;
                  o_mem_wdata <= fpr[first_s];
                  wb_val_r <= i_base;
                  wb_en_r  <= 1'b0;
                  if (i_op == OP_POP) begin
                    o_mem_addr <= i_base;
                    wb_val_r   <= sp_hi;
                    wb_en_r    <= 1'b1;
                  end else if (i_op == OP_PUSH) begin
                    o_mem_addr <= sp_lo;
                    wb_val_r   <= sp_lo;
                    wb_en_r    <= 1'b1;
                  end else if (i_op == OP_STR) begin
                    o_mem_addr <= str_addr;
                  end else if (i_decrement) begin
                    o_mem_addr <= sp_lo;
                    wb_val_r   <= sp_lo;
                    wb_en_r    <= 1'b1;
                  end else begin
                    o_mem_addr <= i_base;
                    wb_val_r   <= sp_hi;
                    wb_en_r    <= i_writeback;
                  end
                end
                OP_SQRT: begin
                  busy_r  <= 1'b1;
                  done_r  <= 1'b0;
                  state_r <= ST_SQRT;
                  dst_r   <= i_dst;
                end
                OP_DSB: begin
                  busy_r  <= 1'b1;
                  done_r  <= 1'b0;
                  state_r <= ST_DSB;
                end
                OP_BREAKPOINT_INSTR: o_debug_req <= 1'b1;
                OP_ISB:  o_pipe_flush <= 1'b1;
                default: ;
              endcase
            end
          end
        end
        ST_MEM: begin
          if (!o_mem_req) begin
            o_mem_req <= mem_go;
          end else if (i_mem_ack) begin
            idx_r      <= idx_r + 5'h01;
            left_r     <= left_r - 6'h01;
            o_mem_addr <= o_mem_addr + 32'h4;
            o_mem_wdata <= fpr[idx_r + 5'h01];
            if (left_r == 6'h01) begin
              o_mem_req       <= 1'b0;
              o_base_wb_valid <= wb_en_r;
              o_base_wb_value <= wb_val_r;
              done_r  <= 1'b1;
              busy_r  <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_SQRT: begin
          if (cnt_r == 5'h00) begin
            done_r  <= 1'b1;
            busy_r  <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        ST_DSB: begin
          if (i_mem_idle) begin
            done_r  <= 1'b1;
            busy_r  <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Pending data barrier; DATA_MEMORY_BARRIER itself retires at once.
  // no stall for non-memory work
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      dmb_pend_r <= 1'b0;
    else if (accept && exec && i_op == OP_DMB)
      dmb_pend_r <= 1'b1;
    else if (state_r == ST_MEM && !o_mem_req && i_mem_idle)
      dmb_pend_r <= 1'b0;
  end

  //--------------------------------------------------------------
  // Square root, one result bit per cycle
  //--------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rad_r  <= 48'h0;
      rem_r  <= 26'h0;
      root_r <= 24'h0;
      cnt_r  <= 5'h00;
      sq_exp_r      <= 9'h000;
      sq_spec_r     <= 1'b0;
      sq_spec_val_r <= 32'h0;
    end else if (accept && exec && i_op == OP_SQRT) begin
      // Odd biased exponent means even true exponent
      rad_r  <= fpr[i_src_a][23] ? {1'b0, 1'b1, fpr[i_src_a][22:0], 23'h0}
                                 : {1'b1, fpr[i_src_a][22:0], 24'h0};
      rem_r  <= 26'h0;
      root_r <= 24'h0;
      cnt_r  <= `SQRT_STEPS;
      sq_exp_r <= ({1'b0, fpr[i_src_a][30:23]} + `FP_SQRT_BIAS
                   + {8'h00, fpr[i_src_a][23]}) >> 1;
      sq_spec_r <= 1'b1;
      if (fpr[i_src_a][30:23] == 8'h00)
        sq_spec_val_r <= {fpr[i_src_a][31], 31'h0};
      else if (fpr[i_src_a][31])
        sq_spec_val_r <= `FP_NAN;
      else if (fpr[i_src_a][30:23] == `FP_EXP_MAX)
        sq_spec_val_r <= fpr[i_src_a];
      else
        sq_spec_r <= 1'b0;
    end else if (state_r == ST_SQRT && cnt_r != 5'h00) begin
      rad_r <= {rad_r[45:0], 2'b00};
      cnt_r <= cnt_r - 5'h01;
      if (rem_n >= trial) begin
        rem_r  <= 26'(rem_n - trial);
        root_r <= {root_r[22:0], 1'b1};
      end else begin
        rem_r  <= rem_n[25:0];
        root_r <= {root_r[22:0], 1'b0};
      end
    end
  end

  //--------------------------------------------------------------
  // Output drive
  //--------------------------------------------------------------
  assign o_busy = busy_r;
  assign o_done = done_r;

endmodule

// ### hw/fp_sys_exec_defs.svh
// Constants for the floating-point store and system instruction unit.
// Assumes a single core clock and that the decoder hands over fields.
// Function
// - Pop loads consecutive extension registers from successive stack words.
// - Push stores one to sixteen consecutive extension registers onto the stack.
// - Square root of one single-precision source written to destination.
// - Subtract second single operand from first, write difference.
// - Increment-after, the default, writes ascending addresses from base.
// - Decrement-before ends just below base and needs base writeback.
// - With writeback the base register takes the modified address afterwards.
// - Single store writes one word or doubleword at base plus offset.
// - Single store offset is multiple of 4, 0 to 1020, plus or minus.
// - Pop, push, store, square root and subtract keep flags.
// - Breakpoint enters debug state and ignores its 8-bit immediate.
// - Breakpoint inside a conditional block always executes.
// - Mask set form sets, clear form clears selected interrupt or fault mask.
// - Unprivileged change-processor-state leaves both masks unchanged.
// - Data memory barrier completes earlier accesses before later ones start.
// - Data memory barrier does not stall non-memory instructions.
// - Sync barrier completes after earlier accesses; later instructions wait.
// - Instruction barrier flushes the pipeline so later instructions refetch.
`ifndef FP_SYS_EXEC_DEFS_SVH
`define FP_SYS_EXEC_DEFS_SVH

`define FP_NAN       32'h7fc00000
`define FP_EXP_MAX   8'hff
`define FP_SQRT_BIAS 9'h07e
`define SQRT_STEPS   5'h18
`define SUB_SHIFT_MAX 8'h1a
`define MASK_RST     1'b0
`define NUM_SREGS    32

`endif

// ### hw/fp_sys_exec_pkg.sv
// Types for the floating-point store and system instruction unit.
// Assumes the decoder drives op codes of this enumeration.
package fp_sys_exec_pkg;

  typedef enum logic [3:0] {
    OP_NONE, OP_POP, OP_PUSH, OP_STM, OP_STR, OP_SQRT, OP_SUB,
    OP_BREAKPOINT_INSTR, OP_CPS, OP_DMB, OP_DSB, OP_ISB
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE, ST_MEM, ST_SQRT, ST_DSB
  } state_t;

endpackage

// ### test/fp_sys_exec_properties.sv
// Port assertions for the execution unit.
// Assumes one clock and the unit's async active-low reset.
`timescale 1ns/1ps

module fp_sys_exec_properties
  import fp_sys_exec_pkg::*;
(
  input wire logic        i_ref_clk,            // Clock
  input wire logic        i_reset_n,            // Reset
  input wire logic        i_issue_valid,        // Offer
  input wire op_t         i_op,                 // Operation
  input wire logic        i_cond_pass,          // Condition
  input wire logic        i_privileged,         // Privilege
  input wire logic        i_sel_int,            // i flag
  input wire logic        i_mask_set,           // Set form
  input wire logic        i_mem_ack,            // Word taken
  input wire logic        i_mem_idle,           // Memory idle
  input wire logic        o_busy,               // Busy
  input wire logic        o_done,               // Retire
  input wire logic        o_mem_req,            // Request
  input wire logic [31:0] o_mem_addr,           // Address
  input wire logic [31:0] o_mem_wdata,          // Store data
  input wire logic        o_base_wb_valid,      // Base update
  input wire logic        o_debug_req,          // Debug entry
  input wire logic        o_pipe_flush,         // Refetch
  input wire logic        o_interrupt_mask_bit, // Int mask
  input wire logic        o_fault_mask_bit      // Fault mask
);
  // ----
  // Offer accepted at this edge
  // ----
  logic take;
  assign take = i_issue_valid && !o_busy;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  AST_BREAKPOINT_INSTR_ALWAYS: assert property (
    take && i_op == OP_BREAKPOINT_INSTR |=> o_debug_req && o_done)
    else $error("breakpoint did not enter debug");
  AST_FLUSH: assert property (
    take && i_op == OP_ISB && i_cond_pass |=> o_pipe_flush && o_done)
    else $error("barrier did not flush");
  AST_CPS_SET: assert property (
    take && i_op == OP_CPS && i_privileged && i_mask_set && i_sel_int
    |=> o_interrupt_mask_bit) else $error("interrupt mask not set");
  AST_CPS_UNPRIV: assert property (
    take && i_op == OP_CPS && !i_privileged
    |=> $stable({o_interrupt_mask_bit, o_fault_mask_bit}))
    else $error("unprivileged mask change");
  AST_MASK_KEEP: assert property (
    !(take && i_op == OP_CPS)
    |=> $stable({o_interrupt_mask_bit, o_fault_mask_bit}))
    else $error("mask changed without mask instruction");
  AST_COND_FALSE: assert property (
    take && !i_cond_pass && !(i_op inside {OP_BREAKPOINT_INSTR, OP_CPS})
    |=> o_done && !o_busy && !o_mem_req && !o_base_wb_valid)
    else $error("failed condition had an effect");
  AST_DSB_WAIT: assert property (
    take && i_op == OP_DSB && i_cond_pass ##1 !i_mem_idle
    |=> o_busy && !o_done) else $error("sync barrier retired early");
  AST_ADDR_STEP: assert property (
    o_mem_req && i_mem_ack ##1 o_mem_req
    |-> o_mem_addr == $past(o_mem_addr) + 32'h4)
    else $error("transfer address not ascending by 4");
  AST_REQ_HOLD: assert property (
    o_mem_req && !i_mem_ack
    |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_wdata))
    else $error("request changed before ack");
  AST_WB_DONE: assert property (
    o_base_wb_valid |-> o_done) else $error("base update without retire");
  AST_SQRT_LAT: assert property (
    take && i_op == OP_SQRT && i_cond_pass |-> ##26 o_done)
    else $error("square root latency wrong");
endmodule

bind fp_sys_exec fp_sys_exec_properties u_props (.*);

// ### test/mem_partner.sv
// Memory partner for the unit's transfer port.
// Assumes the unit holds each request until acknowledged.
`timescale 1ns/1ps

module mem_partner (
  input  wire logic        i_ref_clk, // Clock
  input  wire logic        i_reset_n, // Reset
  input  wire logic        i_req,     // Request
  input  wire logic [31:0] i_addr,    // Word address
  input  wire logic        i_hold,    // Bench keeps busy
  output logic             o_ack,     // Word accepted
  output logic [31:0]      o_rdata,   // Load data
  output logic             o_idle     // Nothing pending
);
  logic [1:0] wait_r;

  // Addresses 0x4xxxxxxx read back as themselves, for float values
  function automatic logic [31:0] pat(input logic [31:0] a);
    return (a[31:28] == 4'h4) ? a : {a[15:0], ~a[15:0]};
  endfunction

  // load words
  // Inverted outside ack so a stale sample cannot pass
  assign o_rdata = o_ack ? pat(i_addr) : ~pat(i_addr);
  assign o_idle  = !i_req && !o_ack && !i_hold;

  // Ack after 0 to 2 wait cycles, one pulse per word
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ack  <= 1'b0;
      wait_r <= 2'h0;
    end else if (i_req && !o_ack && wait_r == 2'h0) begin
      o_ack  <= 1'b1;
      wait_r <= 2'($urandom % 3);
    end else begin
      o_ack <= 1'b0;
      if (i_req && !o_ack) wait_r <= wait_r - 2'h1;
    end
  end
endmodule

// ### test/test_fp_sys_exec.sv
// Self-checking bench for the execution unit.
// Assumes the package, checker and memory partner compile first.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; \
  if ((got) !== (ex)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module test_fp_sys_exec import fp_sys_exec_pkg::*;;
  logic i_ref_clk = 0, i_reset_n = 0, i_issue_valid = 0, i_cond_pass = 0;
  logic i_privileged = 0, i_dbl = 0, i_decrement = 0, i_writeback = 0;
  logic i_imm_sub = 0, i_sel_int = 0, i_sel_fault = 0, i_mask_set = 0;
  logic i_mem_ack, i_mem_idle, hold = 0, leak = 0, em_i = 0, em_f = 0;
  logic o_busy, o_done, o_mem_req, o_mem_we, o_base_wb_valid;
  logic o_debug_req, o_pipe_flush, o_interrupt_mask_bit, o_fault_mask_bit;
  logic [4:0]  i_first_reg = 0, i_reg_count = 0, i_dst = 0, t;
  logic [4:0]  i_src_a = 0, i_src_b = 0, i_dbg_idx = 0;
  logic [7:0]  i_imm_words = 0, w;
  logic [31:0] i_base = 0, i_mem_rdata, o_mem_addr, o_mem_wdata, e32;
  logic [31:0] o_base_wb_value, o_dbg_data, sr [32];
  logic [64:0] qm [$], m, g;
  logic [31:0] qwb [$];
  logic [3:0]  qd [$], e4;
  op_t         i_op = OP_NONE;
  op_t         ops [6] = '{OP_BREAKPOINT_INSTR, OP_BREAKPOINT_INSTR, OP_ISB, OP_ISB, OP_SUB, OP_DSB};
  logic [4:0]  cps_tab [5] = '{5'h1b, 5'h07, 5'h1c, 5'h19, 5'h15};
  int          n_errors = 0, checks_done = 0, cyc = 0, lat;

  always #5 i_ref_clk = ~i_ref_clk;

  fp_sys_exec dut_u (.*);
  mem_partner mem_u (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_req(o_mem_req), .i_addr(o_mem_addr), .i_hold(hold),
    .o_ack(i_mem_ack), .o_rdata(i_mem_rdata), .o_idle(i_mem_idle));

  function automatic logic [31:0] pat(input logic [31:0] a);
    return (a[31:28] == 4'h4) ? a : {a[15:0], ~a[15:0]};
  endfunction

  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Run is about 500 cycles; cut a hang well beyond that
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  // Offer one instruction and wait for its retire pulse
  task automatic iss(op_t op, logic c = 1, logic [4:0] fr = 0, cnt = 1,
      logic [31:0] b = 0, logic d = 0, dec = 0, wb = 0,
      logic [7:0] im = 0, logic su = 0, logic [4:0] ds = 0, sa = 0,
      sb = 0, logic si = 0, sf = 0, ms = 0, pr = 1);
    if (op == OP_CPS && pr && si) em_i = ms;
    if (op == OP_CPS && pr && sf) em_f = ms;
    qd.push_back({op == OP_BREAKPOINT_INSTR, op == OP_ISB && c, em_i, em_f});
    @(posedge i_ref_clk);
    i_issue_valid <= 1'b1;
    i_op <= op;
    {i_cond_pass, i_first_reg, i_reg_count, i_base} <= {c, fr, cnt, b};
    {i_dbl, i_decrement, i_writeback, i_imm_words} <= {d, dec, wb, im};
    {i_imm_sub, i_dst, i_src_a, i_src_b} <= {su, ds, sa, sb};
    {i_sel_int, i_sel_fault, i_mask_set, i_privileged} <= {si, sf, ms, pr};
    @(posedge i_ref_clk);
    i_issue_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge i_ref_clk);
      lat++;
    end while (o_done !== 1'b1 && lat < 200);
    if (lat >= 200) begin
      n_errors++;
      summarize();
    end
  endtask

  // Transfer: note every word and base update it should produce
  task automatic xf(op_t op, logic c, logic [4:0] fr, cnt,
      logic [31:0] b, logic d = 0, dec = 0, wb = 0,
      logic [7:0] im = 0, logic su = 0);
    int nw, r;
    logic [31:0] a;
    nw = (op == OP_STR) ? (d ? 2 : 1) : cnt * (d ? 2 : 1);
    r = d ? 2 * fr : fr;
    if (op == OP_PUSH || dec) a = b - 4 * nw;
    else if (op == OP_STR) a = su ? b - 4 * im : b + 4 * im;
    else a = b;
    for (int k = 0; c && k < nw; k++) begin
      qm.push_back({op != OP_POP, a + 4 * k, sr[(r + k) % 32]});
      if (op == OP_POP) sr[(r + k) % 32] = pat(a + 4 * k);
    end
    if (c && op == OP_POP) qwb.push_back(b + 4 * nw);
    else if (c && (op == OP_PUSH || dec)) qwb.push_back(a);
    else if (c && op == OP_STM && wb) qwb.push_back(b + 4 * nw);
    iss(op, c, fr, cnt, b, d, dec, wb, im, su);
  endtask

  // ----
  // Monitor: oldest note against each result
  // ----
  always @(negedge i_ref_clk) begin
    if (hold && o_mem_req) leak = 1'b1;
    if (o_done === 1'b1) begin
      e4 = qd.size() ? qd.pop_front() : 4'hx;
      t = {1'b0, o_debug_req, o_pipe_flush, o_interrupt_mask_bit,
           o_fault_mask_bit};
      `CHK("done_flags", e4, t[3:0])
    end
    if (o_base_wb_valid === 1'b1) begin
      e32 = qwb.size() ? qwb.pop_front() : 32'hx;
      `CHK("base_wb", e32, o_base_wb_value)
    end
    if (o_mem_req === 1'b1 && i_mem_ack === 1'b1) begin
      m = qm.size() ? qm.pop_front() : 65'hx;
      g = {o_mem_we, o_mem_addr, o_mem_we ? o_mem_wdata : m[31:0]};
      `CHK("mem_word", m, g)
    end
  end

  initial begin
    void'($urandom(18));
    repeat (12) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    // lists of 1 to 16, base never the PC
    xf(OP_POP, 1, 0, 16, 32'h1000_0100, 1);
    xf(OP_POP, 1, 8, 1, 32'h4080_0000);
    xf(OP_POP, 1, 9, 1, 32'h4110_0000);
    xf(OP_PUSH, 1, 0, 8, 32'h2000_0040);
    xf(OP_PUSH, 1, 0, 16, 32'h2000_1000, 1);
    $display("test stack done");
    xf(OP_STM, 1, 0, 2, 32'h3000_0000, 1, 0, 1);
    xf(OP_STM, 1, 2, 1, 32'h3000_0100, 1, 0, 0);
    xf(OP_STM, 1, 5, 3, 32'h3000_1000, 0, 1, 1);
    xf(OP_STM, 0, 0, 4, 32'h3000_2000, 0, 0, 1);
    for (int k = 0; k < 4; k++) begin
      w = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom % 256);
      xf(OP_STR, 1, 5'(3 + k), 1, 32'h5000_0800, k[0], 0, 0, w, k[1]);
    end
    $display("test stores done");
    iss(OP_SQRT, 1, 0, 1, 0, 0, 0, 0, 0, 0, 10, 8);
    `CHK("sqrt_lat", 26, lat)
    iss(OP_SUB, 1, 0, 1, 0, 0, 0, 0, 0, 0, 11, 9, 8);
    iss(OP_SQRT, 0, 0, 1, 0, 0, 0, 0, 0, 0, 10, 9);
    for (int k = 0; k < 6; k++) iss(ops[k], k[0]);
    sr[10] = 32'h4000_0000;
    sr[11] = 32'h40a0_0000;
    for (int k = 0; k < 12; k++) begin
      @(posedge i_ref_clk);
      i_dbg_idx <= 5'(k);
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      `CHK("fp_reg", sr[k], o_dbg_data)
    end
    $display("test float done");
    for (int k = 0; k < 5; k++) begin
      t = cps_tab[k];
      iss(OP_CPS, t[4], 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, t[3], t[2], t[1],
          t[0]);
    end
    $display("test masks done");
    hold <= 1'b1;
    fork
      iss(OP_DSB, 1);
      begin
        repeat (8) @(posedge i_ref_clk);
        hold <= 1'b0;
      end
    join
    `CHK("dsb_wait", 1'b1, lat >= 8)
    hold <= 1'b1;
    fork
      begin
        iss(OP_DMB, 1);
        `CHK("dmb_lat", 1, lat)
        xf(OP_STR, 1, 1, 1, 32'h5000_0000);
      end
      begin
        repeat (10) @(posedge i_ref_clk);
        hold <= 1'b0;
      end
    join
    `CHK("dmb_order", 1'b0, leak)
    $display("test barriers done");
    repeat (4) @(posedge i_ref_clk);
    `CHK("notes_left", 0, qm.size() + qwb.size() + qd.size())
    summarize();
  end
endmodule
